// ===== core/sadc_dev.sv
// Device end: serial frame, result coding and internal scan FIFO
//
// Notes on behaviour
// - Host clock at most 8 MHz, mode 3
// - Input on rising, output on falling clock
// - Chip select fall opens frame, samples in external mode
// - Host clocks at least sixteen bits per frame
// - Tag on: channel nibble then result MSB-first
// - Tag off, external mode: zero, result, zero padding
// - Unipolar negative difference gives code zero
// - Single-ended always unipolar against ground
// - Pseudo-differential inputs reference last channel
// - Straight binary unipolar, two's complement bipolar
// - Differential reference saturates at top code
// - Internal results kept in sixteen-entry FIFO
// - Full FIFO overwrites oldest result
// - Entry is tag plus result, oldest first
// - Empty FIFO shifts out zeros
// - Host soft-resets when leaving internal mode
// - External mode samples at select fall
// - Channel given one frame, result next
// - Internal scan timed by on-chip oscillator
// - Start pulse with select high runs scan
// - End flag low after scan until select fall or restart
// - Host waits end flag before select or restart
`default_nettype none
module sadc_dev
  import sadc_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  sadc_if.dev lnk,
  input wire logic int_clock_mode,
  input wire logic chan_tag_enable,
  input wire logic res10,
  input wire logic single_ended,
  input wire logic bipolar,
  input wire logic pseudo_diff_common,
  input wire logic diff_ref_select,
  input wire logic [RES_W-1:0] ref_span,
  input wire logic [TAG_W-1:0] scan_last,
  input wire logic [RES_W-1:0] ana_pos,
  input wire logic [RES_W-1:0] ana_neg,
  output logic [TAG_W-1:0] mux_pos_sel,
  output logic [TAG_W-1:0] mux_neg_sel,
  output logic sample_pulse
);
  // ---------------------------------------------------------------
  // Pin synchronisers and edges
  // ---------------------------------------------------------------
  logic [1:0] sclk_s, cs_s, din_s, cnv_s;
  logic sclk_q, cs_q, cnv_q;
  logic sclk_rise, sclk_fall, cs_fall, cs_rise, cnv_fall;

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      sclk_s <= 2'h3;
      cs_s <= 2'h3;
      din_s <= 2'h0;
      cnv_s <= 2'h3;
      sclk_q <= 1'b1;
      cs_q <= 1'b1;
      cnv_q <= 1'b1;
    end
    else
    begin
      sclk_s <= {sclk_s[0], lnk.sclk};
      cs_s <= {cs_s[0], lnk.cs_n};
      din_s <= {din_s[0], lnk.din};
      cnv_s <= {cnv_s[0], lnk.conv_start_n};
      sclk_q <= sclk_s[1];
      cs_q <= cs_s[1];
      cnv_q <= cnv_s[1];
    end
  end

  // Edges only count inside a frame, so an idle clock is harmless
  assign sclk_rise = sclk_s[1] & ~sclk_q & ~cs_s[1];
  assign sclk_fall = ~sclk_s[1] & sclk_q & ~cs_s[1];
  assign cs_fall = ~cs_s[1] & cs_q;
  assign cs_rise = cs_s[1] & ~cs_q;
  assign cnv_fall = ~cnv_s[1] & cnv_q;

  // ---------------------------------------------------------------
  // Result coding
  // ---------------------------------------------------------------
  function automatic logic [RES_W-1:0] code_f(
    input logic [RES_W-1:0] p,
    input logic [RES_W-1:0] n,
    input logic uni,
    input logic dref,
    input logic [RES_W-1:0] span
  );
    logic signed [RES_W:0] d;
    d = $signed({1'b0, p}) - $signed({1'b0, n});
    if (uni)
    begin
      if (d < 0)
        code_f = '0;
      else if (dref && d[RES_W-1:0] > span)
        code_f = CODE_MAX;
      else
        code_f = d[RES_W-1:0];
    end
    else
    begin
      if (dref && d > $signed({1'b0, span}))
        code_f = CODE_BIP_MAX;
      else
        code_f = d[RES_W:1];
    end
  endfunction

  function automatic logic [WORD_W-1:0] fmt_f(
    input logic [TAG_W-1:0] tag,
    input logic [RES_W-1:0] code,
    input logic tagen,
    input logic r10
  );
    if (tagen)
      fmt_f = {tag, code};
    else if (r10)
      fmt_f = {1'b0, code[RES_W-1:LSB10], {PAD10{1'b0}}};
    else
      fmt_f = {1'b0, code, {PAD12{1'b0}}};
  endfunction

  logic uni;
  logic [RES_W-1:0] neg_val, code_now;
  // Single-ended ignores the bipolar setting and the negative pin
  assign uni = single_ended | ~bipolar;
  assign neg_val = single_ended ? '0 : ana_neg;
  assign code_now = code_f(ana_pos, neg_val, uni, diff_ref_select, ref_span);

  // ---------------------------------------------------------------
  // Internal scan sequencer
  // ---------------------------------------------------------------
  typedef enum logic {SADC_IDLE, SADC_CONV} sadc_st_t;
  sadc_st_t st_r, st_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [TAG_W-1:0] scan_ch_r, scan_ch_nxt;
  logic eoc_n_r, eoc_n_nxt;
  logic push, soft_rst;

  always_comb
  begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    scan_ch_nxt = scan_ch_r;
    eoc_n_nxt = eoc_n_r;
    push = 1'b0;
    if (cs_fall || cnv_fall)
      eoc_n_nxt = 1'b1;
    unique case (st_r)
      SADC_IDLE:
      begin
        if (cnv_fall && cs_s[1] && int_clock_mode)
        begin
          st_nxt = SADC_CONV;
          cnt_nxt = '0;
          scan_ch_nxt = '0;
          eoc_n_nxt = 1'b1;
        end
      end
      SADC_CONV:
      begin
        eoc_n_nxt = 1'b1;
        cnt_nxt = cnt_r + 1'b1;
        // Nominal oscillator period; the tolerance is not modelled
        if (cnt_r == CNT_W'(CONV_CYC - 1))
        begin
          push = 1'b1;
          cnt_nxt = '0;
          scan_ch_nxt = scan_ch_r + 1'b1;
          if (scan_ch_r == scan_last)
          begin
            st_nxt = SADC_IDLE;
            eoc_n_nxt = 1'b0;
          end
        end
      end
    endcase
    if (soft_rst)
    begin
      st_nxt = SADC_IDLE;
      eoc_n_nxt = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      st_r <= SADC_IDLE;
      cnt_r <= '0;
      scan_ch_r <= '0;
      eoc_n_r <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      scan_ch_r <= scan_ch_nxt;
      eoc_n_r <= eoc_n_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Result FIFO
  // ---------------------------------------------------------------
  logic [WORD_W-1:0] mem [FIFO_D];
  logic [PTR_W-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [PTR_W:0] fc_r, fc_nxt;
  logic pop, full, empty;

  assign full = (fc_r == (PTR_W+1)'(FIFO_D));
  assign empty = (fc_r == '0);
  assign pop = cs_fall & int_clock_mode & ~empty;

  always_comb
  begin
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    fc_nxt = fc_r;
    if (soft_rst)
    begin
      wp_nxt = '0;
      rp_nxt = '0;
      fc_nxt = '0;
    end
    else
    begin
      if (push)
        wp_nxt = wp_r + 1'b1;
      if (pop || (push && full))
        rp_nxt = rp_r + 1'b1;
      if (push && !pop && !full)
        fc_nxt = fc_r + 1'b1;
      else if (pop && !push)
        fc_nxt = fc_r - 1'b1;
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      wp_r <= '0;
      rp_r <= '0;
      fc_r <= '0;
    end
    else
    begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      fc_r <= fc_nxt;
    end
  end

  // Storage has no reset; the count guards every read
  always_ff @(posedge clock)
  begin
    if (push)
      mem[wp_r] <= {scan_ch_r, code_now};
  end

  // ---------------------------------------------------------------
  // Serial shifter and channel select
  // ---------------------------------------------------------------
  logic [WORD_W-1:0] so_r, so_nxt, si_r, si_nxt;
  logic [BIT_W-1:0] bits_r, bits_nxt;
  logic dout_r, dout_nxt, smp_r, smp_nxt;
  logic [TAG_W-1:0] chan_r, chan_nxt, pos_r, pos_nxt, neg_r, neg_nxt;

  assign soft_rst = cs_rise && bits_r >= BIT_W'(MIN_BITS)
    && !si_r[CMD_SEL_BIT] && si_r[CMD_RST_HI:CMD_RST_LO] == RST_SOFT;

  always_comb
  begin
    so_nxt = so_r;
    si_nxt = si_r;
    bits_nxt = bits_r;
    dout_nxt = dout_r;
    chan_nxt = chan_r;
    smp_nxt = push;
    // Cleared at frame end, once select has risen, so the pin idles low between frames
    if (cs_rise)
      dout_nxt = 1'b0;
    if (cs_fall)
    begin
      bits_nxt = '0;
      if (!int_clock_mode)
      begin
        smp_nxt = 1'b1;
        so_nxt = fmt_f(pos_r, code_now, chan_tag_enable, res10);
      end
      else if (!empty)
        so_nxt = mem[rp_r];
      else
        so_nxt = '0;
    end
    if (sclk_rise)
    begin
      si_nxt = {si_r[WORD_W-2:0], din_s[1]};
      if (bits_r != '1)
        bits_nxt = bits_r + 1'b1;
    end
    if (sclk_fall)
    begin
      dout_nxt = so_r[WORD_W-1];
      so_nxt = {so_r[WORD_W-2:0], 1'b0};
    end
    // Short frames are ignored: the channel only moves on a full word
    if (cs_rise && bits_r >= BIT_W'(MIN_BITS) && !si_r[CMD_SEL_BIT])
      chan_nxt = si_r[CMD_CHAN_HI:CMD_CHAN_LO];
    pos_nxt = int_clock_mode ? scan_ch_r : chan_r;
    if (pseudo_diff_common)
      neg_nxt = COMMON_CH;
    else
      neg_nxt = pos_nxt | 4'h1;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      so_r <= '0;
      si_r <= '0;
      bits_r <= '0;
      dout_r <= 1'b0;
      chan_r <= '0;
      pos_r <= '0;
      neg_r <= '0;
      smp_r <= 1'b0;
    end
    else
    begin
      so_r <= so_nxt;
      si_r <= si_nxt;
      bits_r <= bits_nxt;
      dout_r <= dout_nxt;
      chan_r <= chan_nxt;
      pos_r <= pos_nxt;
      neg_r <= neg_nxt;
      smp_r <= smp_nxt;
    end
  end

  assign lnk.dout = dout_r;
  assign lnk.dout_oe = ~cs_s[1];
  assign lnk.eoc_n = eoc_n_r;
  assign mux_pos_sel = pos_r;
  assign mux_neg_sel = neg_r;
  assign sample_pulse = smp_r;
endmodule
`default_nettype wire

// ===== core/sadc_pkg.sv
// Shared constants of the converter serial link, coding and scan FIFO
`default_nettype none
package sadc_pkg;
  localparam int WORD_W = 16;
  localparam int TAG_W = 4;
  localparam int RES_W = 12;
  localparam int FIFO_D = 16;
  localparam int PTR_W = 4;
  localparam int MIN_BITS = 16;
  localparam int BIT_W = 5;
  localparam int PAD12 = 3;
  localparam int PAD10 = 5;
  localparam int LSB10 = 2;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam real CLK_MHZ = 250.0;
  localparam real SCLK_MAX_MHZ = 8.0;
  localparam real OSC_MHZ = 13.33;
  localparam real OSC_TOL_PCT = 15.0;
  localparam real CONV_LOW_NS = 5.0;
  localparam int OSC_PER_CONV = 16;
  localparam int SCLK_HALF_CYC = int'($ceil(CLK_MHZ / SCLK_MAX_MHZ / 2.0));
  localparam int CONV_CYC = int'($ceil(OSC_PER_CONV * CLK_MHZ / OSC_MHZ));
  localparam int CONV_LOW_CYC = int'($ceil(CONV_LOW_NS * CLK_MHZ / 1000.0));
  localparam int EOC_GUARD_CYC = 8;
  localparam int CNT_W = $clog2(CONV_CYC + 1);
  // ---------------------------------------------------------------
  // Command word fields
  // ---------------------------------------------------------------
  localparam int CMD_SEL_BIT = 15;
  localparam int CMD_CHAN_HI = 10;
  localparam int CMD_CHAN_LO = 7;
  localparam int CMD_RST_HI = 4;
  localparam int CMD_RST_LO = 3;
  localparam logic [1:0] RST_SOFT = 2'h2;
  localparam logic [WORD_W-1:0] RST_WORD = 16'h0010;
  localparam logic [TAG_W-1:0] COMMON_CH = 4'hF;
  localparam logic [RES_W-1:0] CODE_MAX = 12'hFFF;
  localparam logic [RES_W-1:0] CODE_BIP_MAX = 12'h7FF;
endpackage
`default_nettype wire

// ===== core/sadc_if.sv
// Carrier of the 4-wire link plus conversion start and end pins
`default_nettype none
interface sadc_if;
  logic cs_n;
  logic sclk;
  logic din;
  logic conv_start_n;
  logic dout;
  logic dout_oe;
  logic eoc_n;
  modport dev (
    input cs_n, sclk, din, conv_start_n,
    output dout, dout_oe, eoc_n
  );
  modport host (
    output cs_n, sclk, din, conv_start_n,
    input dout, dout_oe, eoc_n
  );
endinterface
`default_nettype wire

// ===== core/sadc_host.sv
// Host end: mode-3 serial master with conversion start control
`default_nettype none
module sadc_host
  import sadc_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  sadc_if.host lnk,
  input wire logic frame_req,
  input wire logic [WORD_W-1:0] tx_word,
  input wire logic scan_req,
  input wire logic int_clock_mode,
  output logic ready,
  output logic [WORD_W-1:0] rx_word,
  output logic rx_valid,
  output logic scan_done
);
  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] dout_s, eoc_s;

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      dout_s <= 2'h0;
      eoc_s <= 2'h3;
    end
    else
    begin
      dout_s <= {dout_s[0], lnk.dout};
      eoc_s <= {eoc_s[0], lnk.eoc_n};
    end
  end

  // ---------------------------------------------------------------
  // Frame and start sequencer
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    SADC_H_IDLE, SADC_H_LEAD, SADC_H_LOW, SADC_H_HIGH,
    SADC_H_TAIL, SADC_H_CNV, SADC_H_WAIT
  } sadc_hst_t;
  sadc_hst_t st_r, st_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [BIT_W-1:0] bit_r, bit_nxt;
  logic [WORD_W-1:0] tx_r, tx_nxt, rx_r, rx_nxt, rxw_r, rxw_nxt;
  logic cs_r, cs_nxt, sclk_r, sclk_nxt, din_r, din_nxt, cnv_r, cnv_nxt;
  logic val_r, val_nxt, done_r, done_nxt, pend_r, pend_nxt, mode_q;
  logic tick;

  assign tick = (cnt_r == '0);

  always_comb
  begin
    st_nxt = st_r;
    cnt_nxt = tick ? cnt_r : cnt_r - 1'b1;
    bit_nxt = bit_r;
    tx_nxt = tx_r;
    rx_nxt = rx_r;
    rxw_nxt = rxw_r;
    cs_nxt = cs_r;
    sclk_nxt = sclk_r;
    din_nxt = din_r;
    cnv_nxt = cnv_r;
    val_nxt = 1'b0;
    done_nxt = 1'b0;
    pend_nxt = pend_r | (mode_q & ~int_clock_mode);
    unique case (st_r)
      SADC_H_IDLE:
      begin
        if (pend_r || frame_req)
        begin
          tx_nxt = pend_r ? RST_WORD : tx_word;
          pend_nxt = 1'b0;
          cs_nxt = 1'b0;
          bit_nxt = '0;
          cnt_nxt = CNT_W'(SCLK_HALF_CYC - 1);
          st_nxt = SADC_H_LEAD;
        end
        else if (scan_req)
        begin
          cnv_nxt = 1'b0;
          cnt_nxt = CNT_W'(CONV_LOW_CYC - 1);
          st_nxt = SADC_H_CNV;
        end
      end
      SADC_H_LEAD, SADC_H_HIGH:
      begin
        if (tick)
        begin
          if (bit_r == BIT_W'(MIN_BITS))
          begin
            cs_nxt = 1'b1;
            st_nxt = SADC_H_TAIL;
          end
          else
          begin
            sclk_nxt = 1'b0;
            din_nxt = tx_r[WORD_W-1];
            tx_nxt = {tx_r[WORD_W-2:0], 1'b0};
            st_nxt = SADC_H_LOW;
          end
          cnt_nxt = CNT_W'(SCLK_HALF_CYC - 1);
        end
      end
      SADC_H_LOW:
      begin
        if (tick)
        begin
          sclk_nxt = 1'b1;
          rx_nxt = {rx_r[WORD_W-2:0], dout_s[1]};
          bit_nxt = bit_r + 1'b1;
          cnt_nxt = CNT_W'(SCLK_HALF_CYC - 1);
          st_nxt = SADC_H_HIGH;
        end
      end
      SADC_H_TAIL:
      begin
        if (tick)
        begin
          rxw_nxt = rx_r;
          val_nxt = 1'b1;
          st_nxt = SADC_H_IDLE;
        end
      end
      SADC_H_CNV:
      begin
        if (tick)
        begin
          cnv_nxt = 1'b1;
          cnt_nxt = CNT_W'(EOC_GUARD_CYC);
          st_nxt = SADC_H_WAIT;
        end
      end
      SADC_H_WAIT:
      begin
        // Guard lets the end flag rise before its fall is trusted
        if (tick && !eoc_s[1])
        begin
          done_nxt = 1'b1;
          st_nxt = SADC_H_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      st_r <= SADC_H_IDLE;
      cnt_r <= '0;
      bit_r <= '0;
      tx_r <= '0;
      rx_r <= '0;
      rxw_r <= '0;
      cs_r <= 1'b1;
      sclk_r <= 1'b1;
      din_r <= 1'b0;
      cnv_r <= 1'b1;
      val_r <= 1'b0;
      done_r <= 1'b0;
      pend_r <= 1'b0;
      mode_q <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      bit_r <= bit_nxt;
      tx_r <= tx_nxt;
      rx_r <= rx_nxt;
      rxw_r <= rxw_nxt;
      cs_r <= cs_nxt;
      sclk_r <= sclk_nxt;
      din_r <= din_nxt;
      cnv_r <= cnv_nxt;
      val_r <= val_nxt;
      done_r <= done_nxt;
      pend_r <= pend_nxt;
      mode_q <= int_clock_mode;
    end
  end

  assign lnk.cs_n = cs_r;
  assign lnk.sclk = sclk_r;
  assign lnk.din = din_r;
  assign lnk.conv_start_n = cnv_r;
  assign ready = (st_r == SADC_H_IDLE) & ~pend_r;
  assign rx_word = rxw_r;
  assign rx_valid = val_r;
  assign scan_done = done_r;
endmodule
`default_nettype wire

// ===== tb/sadc_props.sv
// Checker of pin timing on the link between the host and device ends
`default_nettype none
module sadc_props
  import sadc_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  input wire logic conv_start_n,
  input wire logic dout,
  input wire logic dout_oe,
  input wire logic eoc_n
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);
  // ---------------------------------------------------------------
  // Helper counters
  // ---------------------------------------------------------------
  logic [4:0] rise_r;
  logic [7:0] low_r;
  logic [7:0] hi_r;
  logic sclk_q;
  logic cs_q;
  // The low and high counters saturate so a long idle never wraps into a false pass
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      rise_r <= '0;
      low_r <= '0;
      hi_r <= '0;
      sclk_q <= 1'b1;
      cs_q <= 1'b1;
    end
    else
    begin
      sclk_q <= sclk;
      cs_q <= cs_n;
      if (!cs_n && cs_q)
        rise_r <= '0;
      else if (!cs_n && sclk && !sclk_q)
        rise_r <= rise_r + 5'h1;
      low_r <= sclk ? 8'h0 : (low_r == 8'hff ? low_r : low_r + 8'h1);
      hi_r <= !(cs_n && conv_start_n) ? 8'h0 : (hi_r == 8'hff ? hi_r : hi_r + 8'h1);
    end
  end
  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  AST_SCLK_IDLE: assert property (cs_n && $past(cs_n) |-> sclk)
    else $error("serial clock not high outside a frame");
  AST_SCLK_HALF: assert property ($rose(sclk) |-> low_r >= SCLK_HALF_CYC)
    else $error("serial clock low half too short");
  AST_FRAME_BITS: assert property ($rose(cs_n) |-> rise_r == 5'h10)
    else $error("frame did not carry sixteen clock rises");
  AST_DIN_ON_FALL: assert property (!cs_n && $changed(din) |-> !sclk)
    else $error("serial input changed while clock high");
  AST_DOUT_ON_FALL: assert property (!cs_n && $changed(dout) |-> !sclk)
    else $error("serial output changed while clock high");
  AST_OE_ON: assert property ($fell(cs_n) |-> ##[1:4] dout_oe)
    else $error("output not enabled after select fall");
  AST_OE_OFF: assert property (cs_n [*5] |-> !dout_oe)
    else $error("output enabled with select high");
  AST_CNV_PULSE: assert property ($fell(conv_start_n) |-> cs_n ##1 !conv_start_n)
    else $error("start pulse too short or select low");
  AST_SCAN_HIGH: assert property ($rose(eoc_n) && cs_n |=> eoc_n [*8])
    else $error("end flag dropped early in scan");
  AST_EOC_CAUSE: assert property ($rose(eoc_n) |-> hi_r <= 8'h6)
    else $error("end flag rose without select or start fall");
  AST_EOC_HOLD: assert property (!eoc_n && hi_r >= 8'h6 |=> !eoc_n)
    else $error("end flag released with no cause");
endmodule
`default_nettype wire

// ===== tb/sadc_tb_top.sv
// Self-checking bench joining the host end and device end over the link
`default_nettype none
module sadc_tb_top
  import sadc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic frame_req, scan_req, int_mode, tag, r10, se, bip, pdc, dref;
  logic ready, rx_valid, scan_done, smp;
  logic [15:0] tx_word, rx_word;
  logic [11:0] span, ana_pos, ana_neg;
  logic [3:0] scan_last, pos_sel, neg_sel, prev;
  logic [11:0] ch_val [16];
  logic [15:0] fq [$];
  int error_cnt, checks_done, smp_cnt;
  always #2 clock = ~clock;
  // Analog values follow the mux half a cycle late, like a settling front end
  always @(negedge clock)
  begin
    ana_pos <= ch_val[pos_sel];
    ana_neg <= ch_val[neg_sel];
  end
  // Counted off the falling edge, away from the launching edge, so the pulse has settled
  always @(negedge clock)
  begin
    if (smp === 1'b1)
      smp_cnt++;
  end
  sadc_if lnk();
  sadc_dev i_sadc_dev(.clock(clock), .nrst(nrst), .lnk(lnk), .int_clock_mode(int_mode),
    .chan_tag_enable(tag), .res10(r10), .single_ended(se), .bipolar(bip),
    .pseudo_diff_common(pdc), .diff_ref_select(dref), .ref_span(span), .scan_last(scan_last),
    .ana_pos(ana_pos), .ana_neg(ana_neg), .mux_pos_sel(pos_sel), .mux_neg_sel(neg_sel),
    .sample_pulse(smp));
  sadc_host i_sadc_host(.clock(clock), .nrst(nrst), .lnk(lnk), .frame_req(frame_req),
    .tx_word(tx_word), .scan_req(scan_req), .int_clock_mode(int_mode), .ready(ready),
    .rx_word(rx_word), .rx_valid(rx_valid), .scan_done(scan_done));
  sadc_props i_sadc_props(.clock(clock), .nrst(nrst), .cs_n(lnk.cs_n), .sclk(lnk.sclk),
    .din(lnk.din), .conv_start_n(lnk.conv_start_n), .dout(lnk.dout), .dout_oe(lnk.dout_oe),
    .eoc_n(lnk.eoc_n));
  // ---------------------------------------------------------------
  // Reference model and tasks
  // ---------------------------------------------------------------
  task automatic end_of_test();
    $display("Counts: checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic logic [11:0] code(input int c);
    int p;
    int n;
    int d;
    p = ch_val[c];
    n = se ? 0 : ch_val[pdc ? 15 : (c | 1)];
    d = p - n;
    if (se || !bip)
      return (d < 0) ? 12'h0 : ((dref && d > int'(span)) ? CODE_MAX : 12'(d));
    return (dref && d > int'(span)) ? CODE_BIP_MAX : 12'(d >>> 1);
  endfunction
  function automatic logic [15:0] fmt(input int c);
    logic [11:0] k;
    k = code(c);
    if (tag)
      return {4'(c), k};
    return r10 ? {1'b0, k[11:2], 5'h00} : {1'b0, k, 3'h0};
  endfunction
  task automatic wait_rx();
    int i;
    for (i = 0; rx_valid !== 1'b1; i++)
    begin
      if (i > 3000)
      begin
        error_cnt++;
        end_of_test();
      end
      @(negedge clock);
    end
  endtask
  task automatic frame(input logic [15:0] w, output logic [15:0] r);
    int i;
    for (i = 0; ready !== 1'b1; i++)
    begin
      if (i > 3000)
      begin
        error_cnt++;
        end_of_test();
      end
      @(negedge clock);
    end
    frame_req = 1'b1;
    tx_word = w;
    @(negedge clock);
    frame_req = 1'b0;
    wait_rx();
    r = rx_word;
    @(negedge clock);
  endtask
  // A frame right after a setting change is not judged: the pair may be set a frame early
  task automatic ext_frame(input logic [3:0] c, input bit judge);
    logic [15:0] r;
    int s0;
    s0 = smp_cnt;
    frame({5'h00, c, 7'h00}, r);
    if (judge)
      check(r, fmt(prev));
    check(16'(smp_cnt - s0), 16'h0001);
    check({12'h000, pos_sel}, {12'h000, c});
    check({12'h000, neg_sel}, {12'h000, pdc ? COMMON_CH : (c | 4'h1)});
    prev = c;
  endtask
  task automatic scan(input logic [3:0] last);
    int i;
    int s0;
    scan_last = last;
    s0 = smp_cnt;
    scan_req = 1'b1;
    @(negedge clock);
    scan_req = 1'b0;
    repeat (50) @(negedge clock);
    check(16'(lnk.eoc_n), 16'h0001);
    for (i = 0; scan_done !== 1'b1; i++)
    begin
      if (i > 20000)
      begin
        error_cnt++;
        end_of_test();
      end
      @(negedge clock);
    end
    for (i = 0; i <= int'(last); i++)
    begin
      fq.push_back({4'(i), code(i)});
      if (fq.size() > FIFO_D)
        void'(fq.pop_front());
    end
    check(16'(lnk.eoc_n), 16'h0000);
    check(16'(smp_cnt - s0), 16'(last) + 16'h0001);
    $display("Scan of %0d channels done", last + 1);
  endtask
  task automatic read_fifo(input int n);
    logic [15:0] r;
    logic [15:0] e;
    repeat (n)
    begin
      frame(16'h8000, r);
      e = (fq.size() > 0) ? fq.pop_front() : 16'h0000;
      check(r, e);
    end
  endtask
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    int i;
    {frame_req, scan_req, int_mode, tag, r10, se, bip, pdc, dref} = '0;
    {tx_word, scan_last, prev} = '0;
    span = 12'hfff;
    {error_cnt, checks_done} = '0;
    i = $urandom(32'h1e8e_3865);
    for (i = 0; i < 16; i++)
      ch_val[i] = 12'($urandom);
    repeat (4) @(negedge clock);
    nrst = 1'b1;
    for (i = 0; i < 8; i++)
    begin
      {tag, r10, se} = {i[0], i[1], i[2]};
      {bip, pdc, dref} = {i[0] ^ i[2], i[1] ^ i[0], i[2] ^ i[1]};
      span = 12'($urandom);
      ext_frame(4'($urandom), 1'b0);
      repeat (3) ext_frame(4'($urandom), 1'b1);
    end
    $display("Test external formats done");
    int_mode = 1'b1;
    scan(4'h2);
    read_fifo(4);
    $display("Test scan and empty read done");
    scan(4'h9);
    scan(4'h9);
    read_fifo(17);
    $display("Test overwrite done");
    scan(4'h2);
    int_mode = 1'b0;
    wait_rx();
    fq.delete();
    @(negedge clock);
    int_mode = 1'b1;
    read_fifo(1);
    int_mode = 1'b0;
    wait_rx();
    @(negedge clock);
    prev = 4'h0;
    ext_frame(4'h5, 1'b1);
    $display("Test soft reset on mode change done");
    end_of_test();
  end
endmodule
`default_nettype wire
